// file: rtl/pgpc_params.svh
// Constants for the general-purpose pin control block
`ifndef PGPC_PARAMS_SVH
`define PGPC_PARAMS_SVH

// Register map
`define PGPC_CFG_ADDR        8'h08
`define PGPC_ADDR_W          8
`define PGPC_DATA_W          8

// Field positions inside the pin configuration register
`define PGPC_BIT_DIR         0
`define PGPC_BIT_LEVEL       1
`define PGPC_BIT_STAGE       2
`define PGPC_BIT_DOUT        3
`define PGPC_BIT_FILT        4
`define PGPC_BIT_ALT         5

// Reset values
`define PGPC_RST_DIR         1'h1
`define PGPC_RST_DOUT        1'h0
`define PGPC_RST_STAGE       1'h0
`define PGPC_RST_FILT        1'h0
`define PGPC_RST_ALT         1'h0

// Timing
`define PGPC_CLK_HZ          20000000
`define PGPC_DEB_TIME_MS     30
`define PGPC_DEB_CYCLES      ((`PGPC_DEB_TIME_MS * `PGPC_CLK_HZ) / 1000)

`endif

// file: rtl/pgpc_pkg.sv
// Types shared by the general-purpose pin control block
package pgpc_pkg;

  // Software-visible configuration fields
  typedef struct packed {
    logic alternate_function_enable;
    logic input_filter_enable;
    logic output_data;
    logic output_stage_type;
    logic direction;
  } pgpc_cfg_s;

  // Whole state of the top module
  typedef struct packed {
    pgpc_cfg_s  cfg;
    logic       alt_loaded;
    logic       sync1;
    logic       sync2;
    logic       pin_out;
    logic       pin_oe_n;
    logic       pin_level;
    logic [7:0] rdata;
    logic       rvalid;
  } pgpc_state_s;

endpackage

// file: rtl/pgpc_deb_if.sv
// Link between the pin controller and its input filter
`timescale 1ns/10ps
interface pgpc_deb_if;
  logic raw;
  logic en;
  logic filt;

  modport filter (input raw, input en, output filt);
  modport user   (output raw, output en, input filt);
endinterface

// file: rtl/pgpc_debounce.sv
// Input filter: level must be stable for a full window before it passes
`timescale 1ns/10ps
module pgpc_debounce
  import pgpc_pkg::*;
#(
  parameter int CYCLES = 600000
) (
  input  wire logic    i_sys_clk,
  input  wire logic    i_rstn,
  pgpc_deb_if.filter   deb
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          lvl;
  } pgpc_deb_state_s;

  pgpc_deb_state_s st_r;
  pgpc_deb_state_s st_nxt;

  // Next state: pass through when off, else wait for a stable window
  always_comb begin
    st_nxt = st_r;
    if (!deb.en) begin
      st_nxt.lvl = deb.raw;
      st_nxt.cnt = '0;
    end else if (deb.raw == st_r.lvl) begin
      st_nxt.cnt = '0;                      // Bounce restarts the window
    end else if (st_r.cnt == LAST) begin
      st_nxt.lvl = deb.raw;
      st_nxt.cnt = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign deb.filt = st_r.lvl;

  // Without filtering the level follows the input one cycle later
  property p_deb_bypass;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      !deb.en |=> (deb.filt == $past(deb.raw));
  endproperty
  a_deb_bypass: assert property (p_deb_bypass) else $error("unfiltered level did not follow input");

  // With filtering a change only passes after the full window
  property p_deb_window;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      ($changed(deb.filt) && $past(deb.en)) |-> ($past(st_r.cnt) == LAST);
  endproperty
  a_deb_window: assert property (p_deb_window) else $error("filtered level changed early");

endmodule

// file: rtl/pgpc_top.sv
// General-purpose pin controller with its configuration register
`timescale 1ns/10ps
`include "pgpc_params.svh"

module pgpc_top
  import pgpc_pkg::*;
#(
  parameter int DEB_CYCLES = `PGPC_DEB_CYCLES
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rstn,
  input  wire logic                     i_reg_wr,
  input  wire logic                     i_reg_rd,
  input  wire logic [`PGPC_ADDR_W-1:0]  i_reg_addr,
  input  wire logic [`PGPC_DATA_W-1:0]  i_reg_wdata,
  input  wire logic                     i_alt_strap,
  input  wire logic                     i_alt_out,
  input  wire logic                     i_alt_oe_n,
  input  wire logic                     i_pin,
  output logic [`PGPC_DATA_W-1:0]       o_reg_rdata,
  output logic                          o_reg_rvalid,
  output logic                          o_pin_out,
  output logic                          o_pin_oe_n,
  output logic                          o_pin_level
);

  pgpc_state_s st_r;
  pgpc_state_s st_nxt;
  logic        hit_wr;
  logic        hit_rd;
  logic        level_sample;

  pgpc_deb_if deb ();

  // Input filter on the synchronised pin level
  pgpc_debounce #(
    .CYCLES (DEB_CYCLES)
  ) u_deb (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .deb       (deb)
  );

  assign deb.raw = st_r.sync2;
  assign deb.en  = st_r.cfg.input_filter_enable;

  // Address decode of the configuration register
  assign hit_wr = i_reg_wr && (i_reg_addr == `PGPC_CFG_ADDR);
  assign hit_rd = i_reg_rd && (i_reg_addr == `PGPC_CFG_ADDR);

  // Level seen by software and by the alternate function
  assign level_sample = st_r.cfg.input_filter_enable ? deb.filt : st_r.sync2;

  // Register image with reserved bits reading as zero
  function automatic logic [7:0] cfg_image(input pgpc_cfg_s c, input logic lvl);
    logic [7:0] v;
    v = 8'h00;
    v[`PGPC_BIT_DIR]   = c.direction;
    v[`PGPC_BIT_LEVEL] = lvl;
    v[`PGPC_BIT_STAGE] = c.output_stage_type;
    v[`PGPC_BIT_DOUT]  = c.output_data;
    v[`PGPC_BIT_FILT]  = c.input_filter_enable;
    v[`PGPC_BIT_ALT]   = c.alternate_function_enable;
    return v;
  endfunction

  // Next state of the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    // Two-stage synchroniser for the pin
    st_nxt.sync1 = i_pin;
    st_nxt.sync2 = st_r.sync1;
    // Factory alternate setting caught once after reset release
    if (!st_r.alt_loaded) begin
      st_nxt.cfg.alternate_function_enable = i_alt_strap;
      st_nxt.alt_loaded = 1'b1;
    end
    // Software write; level bit is read-only, bits 7:6 are dropped
    if (hit_wr) begin
      st_nxt.cfg.direction                 = i_reg_wdata[`PGPC_BIT_DIR];
      st_nxt.cfg.output_stage_type         = i_reg_wdata[`PGPC_BIT_STAGE];
      st_nxt.cfg.output_data               = i_reg_wdata[`PGPC_BIT_DOUT];
      st_nxt.cfg.input_filter_enable       = i_reg_wdata[`PGPC_BIT_FILT];
      st_nxt.cfg.alternate_function_enable = i_reg_wdata[`PGPC_BIT_ALT];
    end
    // Read answer, unmapped address reads zero
    if (i_reg_rd) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = hit_rd ? cfg_image(st_r.cfg, level_sample) : 8'h00;
    end
    // Pin driver
    if (st_r.cfg.alternate_function_enable) begin
      st_nxt.pin_out  = i_alt_out;
      st_nxt.pin_oe_n = i_alt_oe_n;
    end else if (st_r.cfg.direction) begin
      st_nxt.pin_out  = 1'b0;
      st_nxt.pin_oe_n = 1'b1;
    end else if (!st_r.cfg.output_data) begin
      st_nxt.pin_out  = 1'b0;
      st_nxt.pin_oe_n = 1'b0;
    end else begin
      st_nxt.pin_out  = st_r.cfg.output_stage_type;
      st_nxt.pin_oe_n = !st_r.cfg.output_stage_type;
    end
    st_nxt.pin_level = level_sample;
  end

  // State register with documented reset configuration
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r                               <= '0;
      st_r.cfg.direction                 <= `PGPC_RST_DIR;
      st_r.cfg.output_data               <= `PGPC_RST_DOUT;
      st_r.cfg.output_stage_type         <= `PGPC_RST_STAGE;
      st_r.cfg.input_filter_enable       <= `PGPC_RST_FILT;
      st_r.cfg.alternate_function_enable <= `PGPC_RST_ALT;
      st_r.pin_oe_n                      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign o_reg_rdata  = st_r.rdata;
  assign o_reg_rvalid = st_r.rvalid;
  assign o_pin_out    = st_r.pin_out;
  assign o_pin_oe_n   = st_r.pin_oe_n;
  assign o_pin_level  = st_r.pin_level;

  // Sequences for register access
  sequence s_cfg_write;
    hit_wr;
  endsequence

  sequence s_cfg_read;
    hit_rd;
  endsequence

  property p_input_floats;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (st_r.cfg.direction && !st_r.cfg.alternate_function_enable) |=> o_pin_oe_n;
  endproperty
  a_input_floats: assert property (p_input_floats) else $error("input pin is driven");

  property p_drive_low;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (!st_r.cfg.direction && !st_r.cfg.output_data && !st_r.cfg.alternate_function_enable)
        |=> (!o_pin_oe_n && !o_pin_out);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("output 0 not driven low");

  property p_push_pull_high;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (!st_r.cfg.direction && st_r.cfg.output_data && st_r.cfg.output_stage_type
        && !st_r.cfg.alternate_function_enable) |=> (!o_pin_oe_n && o_pin_out);
  endproperty
  a_push_pull_high: assert property (p_push_pull_high) else $error("push-pull 1 not driven high");

  property p_open_drain_high;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (!st_r.cfg.direction && st_r.cfg.output_data && !st_r.cfg.output_stage_type
        && !st_r.cfg.alternate_function_enable) |=> o_pin_oe_n;
  endproperty
  a_open_drain_high: assert property (p_open_drain_high) else $error("open-drain 1 is driven");

  property p_alt_owns_pin;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      st_r.cfg.alternate_function_enable |=>
        (o_pin_oe_n == $past(i_alt_oe_n) && o_pin_out == $past(i_alt_out));
  endproperty
  a_alt_owns_pin: assert property (p_alt_owns_pin) else $error("alternate function lost the pin");

  property p_read_level;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      s_cfg_read |=> (o_reg_rvalid && o_reg_rdata[`PGPC_BIT_LEVEL] == $past(level_sample));
  endproperty
  a_read_level: assert property (p_read_level) else $error("level bit wrong on read");

  property p_write_then_read;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (s_cfg_write ##1 s_cfg_read) |=>
        (o_reg_rdata[7:6] == 2'h0 && o_reg_rdata[`PGPC_BIT_DIR] == $past(i_reg_wdata[`PGPC_BIT_DIR], 2));
  endproperty
  a_write_then_read: assert property (p_write_then_read) else $error("write not read back");

  property p_write_to_pin;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (s_cfg_write and (i_reg_wdata[5:0] == 6'h0C)) |=> ##1 (!o_pin_oe_n && o_pin_out);
  endproperty
  a_write_to_pin: assert property (p_write_to_pin) else $error("push-pull write did not reach pin");

  property p_filter_reset;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      !st_r.alt_loaded |-> (st_r.cfg.direction && !st_r.cfg.input_filter_enable && o_pin_oe_n);
  endproperty
  a_filter_reset: assert property (p_filter_reset) else $error("reset configuration wrong");

endmodule

// file: test/pgpc_pin_model.sv
// Pin-side circuitry: outside driver plus a pull-up on the wire
`timescale 1ns/10ps
module pgpc_pin_model (
  input  wire logic i_drv,
  input  wire logic i_oe_n,
  input  wire logic i_ext_en,
  input  wire logic i_ext_val,
  output logic      o_pin
);
  // Device drive wins, then the outside driver, else the pull-up
  assign o_pin = !i_oe_n ? i_drv : (i_ext_en ? i_ext_val : 1'b1);
endmodule

// file: test/test_pgpc_top.sv
// Self-checking bench for the general-purpose pin controller
`timescale 1ns/10ps
module test_pgpc_top;
  logic       clk = 0, rstn = 0, wr = 0, rd = 0, strap = 0;
  logic       aout = 1, aoe_n = 0, ext_en = 0, ext_val = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [7:0] rdata;
  logic       rvalid, pout, poe_n, plevel, pin;
  int         fails = 0, checks_done = 0;

  // Block under test and the circuitry on its pin
  pgpc_top #(.DEB_CYCLES(8)) i_pgpc_top (.i_sys_clk(clk), .i_rstn(rstn), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_alt_strap(strap), .i_alt_out(aout), .i_alt_oe_n(aoe_n),
    .i_pin(pin), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_pin_out(pout), .o_pin_oe_n(poe_n),
    .o_pin_level(plevel));
  pgpc_pin_model i_pgpc_pin_model (.i_drv(pout), .i_oe_n(poe_n), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .o_pin(pin));

  // 20 MHz clock
  always #25 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One register write, then let the pin settle
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= {2'b00, d[5:0]};
    @(posedge clk);
    wr <= 1'b0;
    cyc(6);
  endtask

  // One register read, answer taken the cycle after
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({7'h00, rvalid}, 8'h01, "read answer");
    chk(rdata, exp, "read data");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Reset state: input, open drain, pulled-up level visible
  task automatic t_reset;
    chk({7'h00, poe_n}, 8'h01, "reset release");
    rreg(8'h08, 8'h03);
  endtask

  // All four output data and stage combinations
  task automatic t_out;
    logic [7:0] v;
    logic       lvl;
    for (int i = 0; i < 4; i++) begin
      v = {4'h0, i[1], i[0], 2'b00};
      lvl = (i == 2) ? 1'b1 : i[1];
      wreg(8'h08, v);
      chk({6'h00, poe_n, pin}, {6'h00, i == 2, lvl}, "output drive");
      rreg(8'h08, v | {6'h00, lvl, 1'b0});
    end
  endtask

  // Input role ignores data and stage; level follows the wire
  task automatic t_in;
    @(posedge clk) begin ext_en <= 1'b1; ext_val <= 1'b0; end
    wreg(8'h08, 8'h0D);
    chk({6'h00, poe_n, plevel}, 8'h02, "input float");
    rreg(8'h08, 8'h0D);
    @(posedge clk) ext_val <= 1'b1;
    cyc(5);
    rreg(8'h08, 8'h0F);
    wreg(8'h09, 8'h00);
    rreg(8'h09, 8'h00);
    rreg(8'h08, 8'h0F);
  endtask

  // Filter drops a short glitch and passes a long change
  task automatic t_filt;
    wreg(8'h08, 8'h11);
    @(posedge clk) ext_val <= 1'b0;
    cyc(4);
    chk({7'h00, plevel}, 8'h01, "glitch held off");
    @(posedge clk) ext_val <= 1'b1;
    cyc(12);
    @(posedge clk) ext_val <= 1'b0;
    cyc(6);
    chk({7'h00, plevel}, 8'h01, "inside window");
    cyc(12);
    chk({7'h00, plevel}, 8'h00, "after window");
    rreg(8'h08, 8'h11);
    wreg(8'h08, 8'h01);
    @(posedge clk) ext_val <= 1'b1;
    cyc(4);
    chk({7'h00, plevel}, 8'h01, "unfiltered");
  endtask

  // Read on the edge after a write, then a read in the same edge as a write
  task automatic t_back;
    @(posedge clk);
    wr <= 1'b1; addr <= 8'h08; wdata <= 8'h05;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({7'h00, rvalid}, 8'h01, "back-to-back answer");
    chk(rdata, 8'h07, "back-to-back data");
    @(posedge clk);
    wr <= 1'b1; rd <= 1'b1; wdata <= 8'h01;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b0;
    #1;
    chk(rdata, 8'h07, "same-edge read sees old value");
    rreg(8'h08, 8'h03);
  endtask

  // Alternate function takes the pin; strap sets it at reset
  task automatic t_alt;
    wreg(8'h08, 8'h21);
    @(posedge clk) aout <= 1'b0;
    cyc(3);
    chk({6'h00, poe_n, pout}, 8'h00, "alt drive low");
    @(posedge clk) aout <= 1'b1;
    cyc(3);
    chk({6'h00, poe_n, pout}, 8'h01, "alt drive high");
    @(posedge clk) aoe_n <= 1'b1;
    cyc(3);
    chk({6'h00, poe_n, pout}, 8'h03, "alt release");
    @(posedge clk) aoe_n <= 1'b0;
    rreg(8'h08, 8'h23);
    @(posedge clk) begin strap <= 1'b1; rstn <= 1'b0; end
    cyc(2);
    @(posedge clk) rstn <= 1'b1;
    cyc(4);
    rreg(8'h08, 8'h23);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    cyc(3);
    t_reset();
    t_out();
    t_in();
    t_filt();
    t_back();
    t_alt();
    conclude();
  end

  // Watchdog against a hang
  initial begin
    #(5000 * 50);
    fails++;
    conclude();
  end
endmodule
